// File: hw/trig_marker_consts.vh
// Constants for the trigger and marker unit.
`ifndef TRIG_MARKER_CONSTS_VH
`define TRIG_MARKER_CONSTS_VH
`define SAMPLE_W 16
`define AMP_W_MARK 14
`define MARK_W 2
`define MARK_LSB 14
`define TRIG_OUT_N 4
`define TRIG_IN_N 2
`define FLAG_N 4
`define SRC_W 3
`define ADDR_W 4
`define REG_TRIG_CFG 4'h0
`define REG_FLAG_SRC 4'h1
`define REG_MARK_EN 4'h2
`define REG_STATUS 4'h3
`define OP_NOP 3'h0
`define OP_PLAY 3'h1
`define OP_IDLE 3'h2
`define OP_SET_TRIG 3'h3
`define OP_WAIT_EDGE 3'h4
`define OP_WAIT_DONE 3'h5
`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_BOTH 2'h2
`endif

// File: hw/trig_marker_unit.v
// Trigger and marker unit of a waveform playback sequencer.
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`include "trig_marker_consts.vh"
module trig_marker_unit (
  input wire I_CLK,
  input wire I_RST_B,
  input wire [3:0] I_TRIG_PIN,
  input wire [2:0] I_CTL_OP,
  input wire [3:0] I_CTL_ARG,
  input wire I_CTL_VALID,
  output reg O_CTL_READY,
  input wire [2:0] I_PLAY_OP,
  input wire I_PLAY_VALID,
  output reg O_PLAY_READY,
  input wire [15:0] I_SAMPLE_A,
  input wire [15:0] I_SAMPLE_B,
  input wire I_SAMPLE_LAST,
  output reg [15:0] O_AMP,
  output reg [1:0] O_MARK,
  output reg O_PLAYING,
  output reg [3:0] O_TRIG_OUT,
  output reg [3:0] O_FLAG,
  input wire [3:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [31:0] O_RDATA
);
  reg [3:0] sync1_r;
  reg [3:0] sync2_r;
  reg [3:0] prev_r;
  reg [7:0] trig_cfg_r;
  reg [11:0] flag_src_r;
  reg mark_en_r;
  reg [3:0] trig_cmd_r;
  reg waiting_r;
  reg playing_r;
  reg [3:0] edge_seen;
  wire [1:0] wait_ch;
  wire ctl_take;
  wire play_take;
  wire play_done;
  wire [1:0] mark_a;
  wire [1:0] mark_b;
  wire [15:0] amp_a;
  wire [15:0] amp_b;
  wire [15:0] amp_sum;
  wire [3:0] trig_now;
  genvar g;
  integer k;

  // Two-stage synchronisers on every trigger pin.
  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      prev_r <= 4'h0;
    end else begin
      sync1_r <= I_TRIG_PIN;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Edge seen per digital trigger channel from its chosen source pin.
  always @* begin
    edge_seen = 4'h0;
    for (k = 0; k < `TRIG_IN_N; k = k + 1) begin
      case (trig_cfg_r[k*4+3 -: 2])
        `EDGE_RISE: edge_seen[k] = sync2_r[trig_cfg_r[k*4 +: 2]] &
          ~prev_r[trig_cfg_r[k*4 +: 2]];
        `EDGE_FALL: edge_seen[k] = ~sync2_r[trig_cfg_r[k*4 +: 2]] &
          prev_r[trig_cfg_r[k*4 +: 2]];
        default: edge_seen[k] = sync2_r[trig_cfg_r[k*4 +: 2]] ^
          prev_r[trig_cfg_r[k*4 +: 2]];
      endcase
    end
  end

  // Control steps are taken when not stalled.
  assign wait_ch = {1'b0, I_CTL_ARG[0]};
  assign play_done = playing_r & I_SAMPLE_LAST & ~(I_PLAY_VALID &
    (I_PLAY_OP == `OP_PLAY || I_PLAY_OP == `OP_IDLE));
  assign ctl_take = I_CTL_VALID & O_CTL_READY;
  assign play_take = I_PLAY_VALID & O_PLAY_READY;

  // Control-step queue: trigger command, edge wait, playback wait.
  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      trig_cmd_r <= 4'h0;
      waiting_r <= 1'b0;
      O_CTL_READY <= 1'b1;
    end else begin
      if (waiting_r) begin
        if ((I_CTL_OP == `OP_WAIT_EDGE && edge_seen[wait_ch]) ||
            (I_CTL_OP == `OP_WAIT_DONE && (!playing_r || play_done))) begin
          waiting_r <= 1'b0;
          O_CTL_READY <= 1'b1;
        end
      end else if (ctl_take) begin
        case (I_CTL_OP)
          `OP_SET_TRIG: trig_cmd_r <= I_CTL_ARG;
          `OP_WAIT_EDGE, `OP_WAIT_DONE: begin
            waiting_r <= 1'b1;
            O_CTL_READY <= 1'b0;
          end
          default: trig_cmd_r <= trig_cmd_r;
        endcase
      end
    end
  end

  // Playback queue: always ready, next entry follows with no gap.
  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      playing_r <= 1'b0;
      O_PLAY_READY <= 1'b1;
    end else begin
      O_PLAY_READY <= 1'b1;
      if (play_take && (I_PLAY_OP == `OP_PLAY || I_PLAY_OP == `OP_IDLE))
        playing_r <= 1'b1;
      else if (playing_r && I_SAMPLE_LAST)
        playing_r <= 1'b0;
    end
  end

  // Split sample words into amplitude and marker bits.
  assign mark_a = mark_en_r ? I_SAMPLE_A[15:14] : 2'h0;
  assign mark_b = mark_en_r ? I_SAMPLE_B[15:14] : 2'h0;
  assign amp_a = mark_en_r ? {I_SAMPLE_A[13:0], 2'h0} : I_SAMPLE_A;
  assign amp_b = mark_en_r ? {I_SAMPLE_B[13:0], 2'h0} : I_SAMPLE_B;
  assign amp_sum = amp_a + amp_b;
  assign trig_now = ctl_take && !waiting_r && I_CTL_OP == `OP_SET_TRIG ?
    I_CTL_ARG : trig_cmd_r;

  // Output stage registers amplitude, markers and triggers together.
  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_AMP <= 16'h0000;
      O_MARK <= 2'h0;
      O_PLAYING <= 1'b0;
      O_TRIG_OUT <= 4'h0;
    end else begin
      O_AMP <= amp_sum;
      O_MARK <= mark_a | mark_b;
      O_PLAYING <= playing_r;
      O_TRIG_OUT <= trig_now;
    end
  end

  // Each flag picks a marker bit or a trigger output, same sample.
  generate
    for (g = 0; g < `FLAG_N; g = g + 1) begin : g_flag
      always @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B)
          O_FLAG[g] <= 1'b0;
        else if (flag_src_r[g*3+2])
          O_FLAG[g] <= trig_now[flag_src_r[g*3 +: 2]];
        else
          O_FLAG[g] <= flag_src_r[g*3] ? mark_a[1] | mark_b[1] :
            mark_a[0] | mark_b[0];
      end
    end
  endgenerate

  // Register port: writes set configuration, reads answer next cycle.
  always @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      trig_cfg_r <= 8'h00;
      flag_src_r <= 12'h000;
      mark_en_r <= 1'b0;
      O_RDATA <= 32'h0000_0000;
    end else begin
      if (I_WR) begin
        case (I_ADDR)
          `REG_TRIG_CFG: trig_cfg_r <= I_WDATA[7:0];
          `REG_FLAG_SRC: flag_src_r <= I_WDATA[11:0];
          `REG_MARK_EN: mark_en_r <= I_WDATA[0];
          default: mark_en_r <= mark_en_r;
        endcase
      end
      if (I_RD) begin
        case (I_ADDR)
          `REG_TRIG_CFG: O_RDATA <= {24'h0, trig_cfg_r};
          `REG_FLAG_SRC: O_RDATA <= {20'h0, flag_src_r};
          `REG_MARK_EN: O_RDATA <= {31'h0, mark_en_r};
          `REG_STATUS: O_RDATA <= {24'h0, trig_cmd_r, sync2_r[1:0],
            waiting_r, playing_r};
          default: O_RDATA <= 32'h0000_0000;
        endcase
      end else begin
        O_RDATA <= 32'h0000_0000;
      end
    end
  end
endmodule // trig_marker_unit

// File: verification/awg_trigger_marker_unit_tb.sv
// Self-checking bench for the trigger and marker unit.
`timescale 1ns/1ps
`include "trig_marker_consts.vh"
module awg_trigger_marker_unit_tb;
  reg I_CLK = 1'h0, I_RST_B = 1'h0, I_CTL_VALID = 1'h0, I_WR = 1'h0;
  reg I_PLAY_VALID = 1'h0, I_SAMPLE_LAST = 1'h0, I_RD = 1'h0;
  reg [2:0] I_CTL_OP = 3'h0, I_PLAY_OP = 3'h1;
  reg [3:0] I_CTL_ARG = 4'h0, I_ADDR = 4'h0, lvl = 4'h2;
  reg [15:0] I_SAMPLE_A = 16'h0, I_SAMPLE_B = 16'h0;
  reg [31:0] I_WDATA = 32'h0;
  wire [3:0] pin, O_TRIG_OUT, O_FLAG;
  wire [31:0] O_RDATA;
  wire [15:0] O_AMP;
  wire [1:0] O_MARK;
  wire O_CTL_READY, O_PLAY_READY, O_PLAYING;
  integer errors = 0, compares = 0, i;
  always #5 I_CLK = ~I_CLK;
  pin_src i_pin_src (.i_clk(I_CLK), .i_lvl(lvl), .o_pin(pin));
  trig_marker_unit i_trig_marker_unit (.I_CLK, .I_RST_B, .I_TRIG_PIN(pin),
    .I_CTL_OP, .I_CTL_ARG, .I_CTL_VALID, .O_CTL_READY, .I_PLAY_OP,
    .I_PLAY_VALID, .O_PLAY_READY, .I_SAMPLE_A, .I_SAMPLE_B, .I_SAMPLE_LAST,
    .O_AMP, .O_MARK, .O_PLAYING, .O_TRIG_OUT, .O_FLAG, .I_ADDR, .I_WDATA,
    .I_WR, .I_RD, .O_RDATA);
  // Counts a comparison and reports a mismatch.
  task chk(input [39:0] n, input [31:0] s, input [31:0] e);
    begin
      compares = compares + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("Error %0s exp %h seen %h", n, e, s);
      end
    end
  endtask
  // One strobe cycle; a read checks the data in the following cycle.
  task bus(input w, input [3:0] a, input [31:0] d);
    begin
      @(posedge I_CLK);
      I_WR <= w;
      I_RD <= !w;
      I_ADDR <= a;
      I_WDATA <= d;
      @(posedge I_CLK);
      I_WR <= 1'h0;
      I_RD <= 1'h0;
      #1;
      if (!w) chk("rdata", O_RDATA, d);
    end
  endtask
  // Offers a step for one cycle, keeps its operation while it stalls.
  task ctl(input [2:0] op, input [3:0] a);
    integer n;
    begin
      @(posedge I_CLK);
      I_CTL_OP <= op;
      I_CTL_ARG <= a;
      I_CTL_VALID <= 1'h1;
      @(posedge I_CLK);
      I_CTL_VALID <= 1'h0;
      for (n = 0; op > 3'h3 && n < 60; n = n + 1) begin
        @(posedge I_CLK);
        #1;
        if (O_CTL_READY === 1'h1) n = 99;
      end
      if (n == 60) chk("stall", 1'h1, 1'h0);
    end
  endtask
  // Waits on a channel while the pins move to a new level.
  task edg(input [3:0] ch, input [3:0] nl);
    fork
      ctl(`OP_WAIT_EDGE, ch);
      begin
        repeat (4) @(posedge I_CLK);
        lvl <= nl;
        repeat (3) @(posedge I_CLK);
        chk("early", O_CTL_READY, 1'h0);
      end
    join
  endtask
  // Drives one pair of sample words and lets them land.
  task smp(input [15:0] a, input [15:0] b);
    begin
      @(posedge I_CLK);
      I_SAMPLE_A <= a;
      I_SAMPLE_B <= b;
      @(posedge I_CLK);
      #1;
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task summarize;
    begin
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // Cuts a hung run short.
  initial begin
    #20000;
    errors = errors + 1;
    summarize;
  end
  // Main test sequence.
  initial begin
    repeat (16) @(posedge I_CLK);
    I_RST_B <= 1'h1;
    bus(1'h1, `REG_FLAG_SRC, 32'hfac);
    bus(1'h0, `REG_FLAG_SRC, 32'hfac);
    bus(1'h0, 4'hf, 32'h0);
    bus(1'h1, `REG_TRIG_CFG, 32'h50);
    for (i = 0; i < 4; i = i + 1) begin
      ctl(`OP_SET_TRIG, 4'h1 << i);
      #1 chk("trig", O_TRIG_OUT, 4'h1 << i);
      chk("flag", O_FLAG, 4'h1 << i);
    end
    $display("trigger test done");
    @(posedge I_CLK);
    I_PLAY_VALID <= 1'h1;
    ctl(`OP_SET_TRIG, 4'h0);
    I_PLAY_OP <= `OP_IDLE;
    #1 chk("clear", {O_PLAYING, O_TRIG_OUT}, 5'h10);
    @(posedge I_CLK);
    I_PLAY_VALID <= 1'h0;
    fork
      ctl(`OP_WAIT_DONE, 4'h0);
      begin
        repeat (4) @(posedge I_CLK);
        chk("ready", O_CTL_READY, 1'h0);
        I_SAMPLE_LAST <= 1'h1;
        @(posedge I_CLK);
        I_SAMPLE_LAST <= 1'h0;
      end
    join
    @(posedge I_CLK);
    #1 chk("play", O_PLAYING, 1'h0);
    edg(4'h1, 4'h0);
    edg(4'h0, 4'h1);
    $display("wait test done");
    bus(1'h1, `REG_FLAG_SRC, 32'h8);
    bus(1'h1, `REG_MARK_EN, 32'h1);
    smp(16'h4005, 16'h0003);
    chk("mark", {O_AMP, O_MARK, O_FLAG}, 22'h81d);
    smp(16'h4005, 16'h8003);
    chk("or", {O_AMP, O_MARK, O_FLAG}, 22'h83f);
    bus(1'h1, `REG_MARK_EN, 32'h0);
    smp(16'h4005, 16'h8003);
    chk("amp", O_AMP, 16'hc008);
    $display("marker test done");
    summarize;
  end
endmodule // awg_trigger_marker_unit_tb

// File: verification/pin_src.sv
// Model of the equipment that drives the trigger pins.
`timescale 1ns/1ps
module pin_src (
  input wire i_clk,
  input wire [3:0] i_lvl,
  output reg [3:0] o_pin
);
  // Pins move off the clock edge, as an unrelated source would.
  always @(posedge i_clk) begin
    o_pin <= #3 i_lvl;
  end
endmodule // pin_src

// File: verification/tmu_chk_assertions.sv
// Port checker for the trigger and marker unit.
`timescale 1ns/1ps
module tmu_chk (
  input wire I_CLK,
  input wire I_RST_B,
  input wire [2:0] I_CTL_OP,
  input wire [3:0] I_CTL_ARG,
  input wire I_CTL_VALID,
  input wire O_CTL_READY,
  input wire I_PLAY_VALID,
  input wire O_PLAY_READY,
  input wire I_SAMPLE_LAST,
  input wire O_PLAYING,
  input wire [3:0] O_TRIG_OUT
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  // A control step taken with the given operation.
  sequence tk(op);
    I_CTL_VALID && O_CTL_READY && I_CTL_OP == op;
  endsequence
  a_trig_value: assert property (tk(3'h3) |=>
    O_TRIG_OUT == $past(I_CTL_ARG)) else $error("trig value");
  a_trig_hold: assert property (!$stable(O_TRIG_OUT) |->
    $past(O_CTL_READY && I_CTL_VALID && I_CTL_OP == 3'h3)) else $error("trig");
  a_set_free: assert property (tk(3'h3) |=> O_CTL_READY)
    else $error("set stalled");
  a_edge_stall: assert property (tk(3'h4) |=> !O_CTL_READY)
    else $error("no stall");
  a_done_stall: assert property (tk(3'h5) ##0
    (O_PLAYING && !I_SAMPLE_LAST) |=> !O_CTL_READY) else $error("no wait");
  a_play_start: assert property (I_PLAY_VALID |=> ##1 O_PLAYING)
    else $error("not playing");
  a_play_end: assert property (O_PLAYING && I_SAMPLE_LAST &&
    !I_PLAY_VALID |=> ##1 !O_PLAYING) else $error("still playing");
  a_play_ready: assert property (O_PLAY_READY)
    else $error("play stalled");
endmodule // tmu_chk
bind trig_marker_unit tmu_chk i_tmu_chk (.I_CLK, .I_RST_B, .I_CTL_OP,
  .I_CTL_ARG, .I_CTL_VALID, .O_CTL_READY, .I_PLAY_VALID, .O_PLAY_READY,
  .I_SAMPLE_LAST, .O_PLAYING, .O_TRIG_OUT);
